// File: rtl/rtccs_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Selector routes none, alarm1, alarm2, wake
// - Polarity bit inverts active output level
// - Calibration output 256 Hz or 1 Hz
// - Hour add/subtract pulses, read as zero
// - Four interrupt enables at bits 15..12
// - Four function enables at bits 11..8
// - Bypass selects live counters over shadows
// - Reference detect enable; divider must be 0xff
// - Stamp edge select rising or falling
// - Wake clock divider or second tick
// - Calibration write sets pending until processed
// - Tamper flags set by pins, clear-by-zero
// - Stamp flag and overflow flag
// - Wake flag set on counter zero
// - Alarm flags set on match
// - Init request enters init, flag shows it
// - Sync flag set on copy, hardware clears
// - Calendar-set flag while year nonzero
// - Shift pending set by write, cleared done
// - Write-allowed flags for alarms and wake
module rtccs_ctrl
	import rtccs_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic             kclk_tick,
	input  wire logic             alarm1_match,
	input  wire logic             alarm2_match,
	input  wire logic             wake_zero,
	input  wire logic             stamp_pin,
	input  wire logic [2:0]       tamper_event,
	input  wire logic             second_tick,
	input  wire logic             cal_clk_256hz,
	input  wire logic             cal_clk_1hz,
	input  wire logic             calib_write,
	input  wire logic             calib_done,
	input  wire logic             shift_write,
	input  wire logic             shift_done,
	input  wire logic             init_ready,
	input  wire logic [7:0]       year_bcd,
	input  wire logic             alarm1_idle,
	input  wire logic             alarm2_idle,
	input  wire logic             wake_idle,
	input  wire logic             shadow_copy,
	output logic                  event_out,
	output logic                  cal_out,
	output logic                  hour_add_pulse,
	output logic                  hour_sub_pulse,
	output logic                  init_mode,
	output logic                  read_live,
	output logic [3:0]            func_en,
	output rtccs_irq_s            irq,
	output rtccs_cfg_s            cfg,
	output logic                  wake_tick_en,
	output logic                  wake_count_ext
);

	// ****************************************
	// Bus slave
	// ****************************************
	logic [7:0]  awaddr_q;
	logic        aw_held_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        w_held_q;
	logic        wr_go;
	logic [31:0] ctrl_q;
	logic [31:0] flags_q;
	logic [31:0] wmask;
	logic [31:0] wr_ctrl;
	logic        wr_ctrl_hit;
	logic        wr_flags_hit;
	logic        stamp_pin_q;
	logic        stamp_evt;
	logic [3:0]  wake_div_q;

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Word decode shared by the write and read paths
	function automatic logic reg_sel(input logic [7:0] a, input logic [7:0] ofs);
		reg_sel = (a[7:2] == ofs[7:2]);
	endfunction

	// A pending response blocks new requests, so one write is in flight at most
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wmask         = strb_mask(wstrb_q);
	assign wr_ctrl_hit   = wr_go && reg_sel(awaddr_q, CTRL_OFS);
	assign wr_flags_hit  = wr_go && reg_sel(awaddr_q, FLAGS_OFS);
	assign wr_ctrl       = (ctrl_q & ~wmask) | (wdata_q & wmask & CTRL_RW_MASK);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held_q <= 1'b0;
		end
	end

	// ****************************************
	// Write response
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			// Unmapped addresses answer slave error
			s_axi_bresp  <= (wr_ctrl_hit || wr_flags_hit) ? 2'h0 : 2'h2;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ****************************************
	// Read path
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			if (reg_sel(s_axi_araddr, CTRL_OFS))
			begin
				s_axi_rdata <= ctrl_q;
				s_axi_rresp <= 2'h0;
			end
			else if (reg_sel(s_axi_araddr, FLAGS_OFS))
			begin
				s_axi_rdata <= flags_q;
				s_axi_rresp <= 2'h0;
			end
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// Control word
	// ****************************************
	// Reserved and hour bits are masked out, so they read back zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl_hit)
			ctrl_q <= wr_ctrl;
	end

	// ****************************************
	// Hour adjust
	// ****************************************
	// Hour bits are not stored, so they always read zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hour_add_pulse <= 1'b0;
			hour_sub_pulse <= 1'b0;
		end
		else
		begin
			hour_add_pulse <= wr_ctrl_hit && wstrb_q[2] && wdata_q[CTRL_HADD];
			// The nonzero-hour guard lives in the calendar datapath
			hour_sub_pulse <= wr_ctrl_hit && wstrb_q[2] && wdata_q[CTRL_HSUB];
		end
	end

	assign func_en   = ctrl_q[CTRL_FEN_LO +: 4];
	assign read_live = ctrl_q[CTRL_BYPASS];
	assign cfg.cal_out_enable      = ctrl_q[CTRL_COUT_EN];
	assign cfg.cal_out_rate_select = ctrl_q[CTRL_CRATE];
	assign cfg.shadow_bypass       = ctrl_q[CTRL_BYPASS];
	assign cfg.mains_ref_detect_en = ctrl_q[CTRL_REFDET];
	assign cfg.stamp_edge_select   = ctrl_q[CTRL_EDGE];
	assign cfg.wake_clock_select   = ctrl_q[2:0];
	assign cfg.hour_format         = ctrl_q[6];
	assign cfg.dst_record          = ctrl_q[18];

	// ****************************************
	// Event output and calibration output
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			event_out <= 1'b0;
			cal_out   <= 1'b0;
		end
		else
		begin
			// Registered so the pin never glitches while flags settle
			case (rtccs_osel_e'(ctrl_q[CTRL_OSEL_LO +: 2]))
				RTCCS_OUT_A1:   event_out <= flags_q[FL_ALARM1] ^ ctrl_q[CTRL_EVENT_OUTPUT_POLARITY];
				RTCCS_OUT_A2:   event_out <= flags_q[FL_ALARM2] ^ ctrl_q[CTRL_EVENT_OUTPUT_POLARITY];
				RTCCS_OUT_WAKE: event_out <= flags_q[FL_WAKE] ^ ctrl_q[CTRL_EVENT_OUTPUT_POLARITY];
				// Unselected output rests at its inactive level
				default:        event_out <= ctrl_q[CTRL_EVENT_OUTPUT_POLARITY];
			endcase
			cal_out <= ctrl_q[CTRL_COUT_EN] &&
				(ctrl_q[CTRL_CRATE] ? cal_clk_1hz : cal_clk_256hz);
		end
	end

	// ****************************************
	// Wake clock selection
	// ****************************************
	// Divide the kernel tick by 16, 8, 4 or 2; upper codes use the second tick
	// Free-running divider: the first tick after a code change has arbitrary phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wake_div_q <= 4'h0;
		else if (kclk_tick)
			wake_div_q <= wake_div_q + 4'h1;
	end

	always_comb
	begin
		wake_tick_en = 1'b0;
		case (ctrl_q[2:1])
			2'h0:    wake_tick_en = kclk_tick && (ctrl_q[0] ? wake_div_q[2:0] == 3'h7
				: wake_div_q == 4'hf);
			2'h1:    wake_tick_en = kclk_tick && (ctrl_q[0] ? wake_div_q[0]
				: wake_div_q[1:0] == 2'h3);
			default: wake_tick_en = second_tick;
		endcase
	end
	assign wake_count_ext = ctrl_q[2] && ctrl_q[1];

	// ****************************************
	// Timestamp edge
	// ****************************************
	assign stamp_evt = ctrl_q[CTRL_FEN_LO + 3] &&
		(ctrl_q[CTRL_EDGE] ? (stamp_pin_q && !stamp_pin) : (!stamp_pin_q && stamp_pin));

	always_ff @(posedge aclk)
	begin
		// Resets low: a pin idling high shows a rising edge, so enable stamps late
		if (!aresetn)
			stamp_pin_q <= 1'b0;
		else
			stamp_pin_q <= stamp_pin;
	end

	// ****************************************
	// Flag word
	// ****************************************
	// Sticky flags: the hardware set wins over a software clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_q <= FLAGS_RESET;
		else
		begin
			for (int i = FL_ALARM1; i <= 15; i++)
				if (wr_flags_hit && wstrb_q[i / 8] && !wdata_q[i])
					flags_q[i] <= 1'b0;
			for (int t = 0; t < 3; t++)
				if (tamper_event[t])
					flags_q[FL_TAMP_LO + t] <= 1'b1;
			if (stamp_evt)
			begin
				flags_q[FL_STAMP] <= 1'b1;
				if (flags_q[FL_STAMP])
					flags_q[FL_STOVF] <= 1'b1;
			end
			if (wake_zero && ctrl_q[CTRL_FEN_LO + 2])
				flags_q[FL_WAKE] <= 1'b1;
			if (alarm2_match && ctrl_q[CTRL_FEN_LO + 1])
				flags_q[FL_ALARM2] <= 1'b1;
			if (alarm1_match && ctrl_q[CTRL_FEN_LO])
				flags_q[FL_ALARM1] <= 1'b1;
			if (wr_flags_hit && wstrb_q[0])
				flags_q[FL_INITREQ] <= wdata_q[FL_INITREQ];
			flags_q[FL_INITACT] <= flags_q[FL_INITREQ] && init_ready;
			if (flags_q[FL_INITREQ] || flags_q[FL_SHIFT] || ctrl_q[CTRL_BYPASS])
				flags_q[FL_SYNCED] <= 1'b0;
			else if (shadow_copy)
				flags_q[FL_SYNCED] <= 1'b1;
			else if (wr_flags_hit && wstrb_q[0] && !wdata_q[FL_SYNCED])
				flags_q[FL_SYNCED] <= 1'b0;
			flags_q[FL_CALSET] <= year_bcd != 8'h00;
			if (shift_write)
				flags_q[FL_SHIFT] <= 1'b1;
			else if (shift_done)
				flags_q[FL_SHIFT] <= 1'b0;
			flags_q[FL_WAKEOK] <= wake_idle || !ctrl_q[CTRL_FEN_LO + 2];
			flags_q[FL_A2OK]   <= alarm2_idle && !ctrl_q[CTRL_FEN_LO + 1];
			flags_q[FL_A1OK]   <= alarm1_idle && !ctrl_q[CTRL_FEN_LO];
			if (calib_write)
				flags_q[FL_RECAL] <= 1'b1;
			else if (calib_done)
				flags_q[FL_RECAL] <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt requests and mode outputs
	// ****************************************
	// Level requests: they drop when software clears the flag or its interrupt enable
	assign init_mode  = flags_q[FL_INITACT];
	assign irq.stamp  = flags_q[FL_STAMP] && ctrl_q[CTRL_IRQ_LO + 3];
	assign irq.wake   = flags_q[FL_WAKE] && ctrl_q[CTRL_IRQ_LO + 2];
	assign irq.alarm2 = flags_q[FL_ALARM2] && ctrl_q[CTRL_IRQ_LO + 1];
	assign irq.alarm1 = flags_q[FL_ALARM1] && ctrl_q[CTRL_IRQ_LO];

endmodule

// File: rtl/rtccs_pkg.sv
package rtccs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  CTRL_OFS      = 8'h08;
	localparam logic [7:0]  FLAGS_OFS     = 8'h0c;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] FLAGS_RESET   = 32'h0000_0007;
	localparam logic [31:0] CTRL_RW_MASK  = 32'h00fc_ff7f;

	// ****************************************
	// Control word fields
	// ****************************************
	localparam int CTRL_COUT_EN   = 23;
	localparam int CTRL_OSEL_LO   = 21;
	localparam int CTRL_EVENT_OUTPUT_POLARITY      = 20;
	localparam int CTRL_CRATE     = 19;
	localparam int CTRL_HSUB      = 17;
	localparam int CTRL_HADD      = 16;
	localparam int CTRL_IRQ_LO    = 12;
	localparam int CTRL_FEN_LO    = 8;
	localparam int CTRL_BYPASS    = 5;
	localparam int CTRL_REFDET    = 4;
	localparam int CTRL_EDGE      = 3;

	// ****************************************
	// Flag word fields
	// ****************************************
	localparam int FL_RECAL    = 16;
	localparam int FL_TAMP_LO  = 13;
	localparam int FL_STOVF    = 12;
	localparam int FL_STAMP    = 11;
	localparam int FL_WAKE     = 10;
	localparam int FL_ALARM2   = 9;
	localparam int FL_ALARM1   = 8;
	localparam int FL_INITREQ  = 7;
	localparam int FL_INITACT  = 6;
	localparam int FL_SYNCED   = 5;
	localparam int FL_CALSET   = 4;
	localparam int FL_SHIFT    = 3;
	localparam int FL_WAKEOK   = 2;
	localparam int FL_A2OK     = 1;
	localparam int FL_A1OK     = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SHADOW_PERIOD_KCLK = 2;

	typedef enum logic [1:0] {RTCCS_OUT_NONE, RTCCS_OUT_A1, RTCCS_OUT_A2, RTCCS_OUT_WAKE}
		rtccs_osel_e;

	typedef struct packed {
		logic alarm1;
		logic alarm2;
		logic wake;
		logic stamp;
	} rtccs_irq_s;

	typedef struct packed {
		logic       cal_out_enable;
		logic       cal_out_rate_select;
		logic       shadow_bypass;
		logic       mains_ref_detect_en;
		logic       stamp_edge_select;
		logic [2:0] wake_clock_select;
		logic       hour_format;
		logic       dst_record;
	} rtccs_cfg_s;

endpackage

// File: test/rtccs_ctrl_chk.sv
`timescale 1ns/1ps
module rtccs_ctrl_chk
	import rtccs_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        alarm1_match,
	input wire logic        cal_clk_256hz,
	input wire logic        cal_clk_1hz,
	input wire logic        init_ready,
	input wire logic        cal_out,
	input wire logic        hour_add_pulse,
	input wire logic        init_mode,
	input wire rtccs_irq_s  irq,
	input wire rtccs_cfg_s  cfg,
	input wire logic        wake_count_ext
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7:2] != CTRL_OFS[7:2] && s_axi_araddr[7:2] != FLAGS_OFS[7:2]
		|=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	irq_cause_a: assert property ($rose(irq.alarm1) |-> $past(alarm1_match) || s_axi_bvalid)
		else $error("alarm irq without cause");
	hour_pulse_a: assert property (hour_add_pulse |-> ($past(s_axi_bvalid) || s_axi_bvalid)
		##1 !hour_add_pulse)
		else $error("hour pulse misplaced");
	init_gate_a: assert property (init_mode |-> $past(init_ready))
		else $error("init mode without ready");
	wake_ext_a: assert property (wake_count_ext == (cfg.wake_clock_select[2:1] == 2'b11))
		else $error("wake count extension wrong");
	cal_out_a: assert property (cal_out == $past(cfg.cal_out_enable
		&& (cfg.cal_out_rate_select ? cal_clk_1hz : cal_clk_256hz)))
		else $error("calibration output wrong");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property ($rose(irq.alarm1));
	cover property ($rose(init_mode));
endmodule

// File: test/test_rtccs_ctrl.sv
`timescale 1ns/1ps
module test_rtccs_ctrl
	import rtccs_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, kclk_tick, alarm1_match, alarm2_match, wake_zero, stamp_pin;
	logic        second_tick, cal_clk_256hz, cal_clk_1hz, calib_write, calib_done, shift_write;
	logic        shift_done, init_ready, alarm1_idle, alarm2_idle, wake_idle, shadow_copy;
	logic        event_out, cal_out, hour_add_pulse, hour_sub_pulse, init_mode, read_live;
	logic        wake_tick_en, wake_count_ext, p;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, year_bcd;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb, func_en;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp_seen;
	logic [2:0]  tamper_event;
	rtccs_irq_s  irq;
	rtccs_cfg_s  cfg;
	int          n_mismatch, n_checks;
	int          n_hadd, n_hsub, n_wtick, w0;

	rtccs_ctrl dut (.*);

	always #5 aclk = ~aclk;

	// Pulses stand one cycle only, so count them as they pass
	always @(negedge aclk)
	begin
		if (hour_add_pulse)
			n_hadd++;
		if (hour_sub_pulse)
			n_hsub++;
		if (wake_tick_en)
			n_wtick++;
	end

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, seen);
			n_mismatch++;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (pa || pw)
		begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			@(posedge aclk);
			pa = pa && !ta;
			pw = pw && !tw;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		ta = 1'b0;
		while (!ta)
		begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			resp_seen = s_axi_bresp;
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		logic t;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = s_axi_rvalid;
			v = s_axi_rdata;
			resp_seen = s_axi_rresp;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
		chk(nm, v & m, e);
		@(posedge aclk);
	endtask

	// One-cycle event pulses, two edges so the flag has landed
	task pulse(input logic [10:0] m);
		{calib_write, calib_done, shift_write, shift_done, shadow_copy, alarm1_match,
			alarm2_match, wake_zero, tamper_event} <= m;
		@(posedge aclk);
		{calib_write, calib_done, shift_write, shift_done, shadow_copy, alarm1_match,
			alarm2_match, wake_zero, tamper_event} <= 11'h0;
		@(posedge aclk);
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{aclk, aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
			s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, kclk_tick, alarm1_match,
			alarm2_match, wake_zero, stamp_pin, tamper_event, second_tick, cal_clk_256hz,
			cal_clk_1hz, calib_write, calib_done, shift_write, shift_done, init_ready,
			year_bcd, shadow_copy} = '0;
		{alarm1_idle, alarm2_idle, wake_idle} = 3'h7;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(CTRL_OFS, 32'hffff_ffff, CTRL_RESET, "ctrl reset");
		rd(FLAGS_OFS, 32'hffff_ffff, FLAGS_RESET, "flags reset");
		$display("reset test done");
		wr(CTRL_OFS, 32'hffff_ffff, 4'hf);
		rd(CTRL_OFS, 32'hffff_ffff, CTRL_RW_MASK, "ctrl mask");
		chk("func_en", 32'(func_en), 32'hf);
		chk("read_live", 32'(read_live), 32'h1);
		wr(CTRL_OFS, 32'h0003_0000, 4'h3);
		chk("hour_add_pulse", 32'(n_hadd), 32'h1);
		chk("hour_sub_pulse", 32'(n_hsub), 32'h1);
		$display("control test done");
		wr(CTRL_OFS, 32'h0000_ff08, 4'hf);
		repeat (2)
		begin
			stamp_pin <= 1'b1;
			repeat (2) @(posedge aclk);
			stamp_pin <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		pulse(11'h03f);
		rd(FLAGS_OFS, 32'h0000_ff00, 32'h0000_ff00, "event flags");
		chk("irq", 32'(irq), 32'hf);
		wr(FLAGS_OFS, 32'h0000_f700, 4'h2);
		rd(FLAGS_OFS, 32'h0000_1800, 32'h0000_1000, "stamp cleared");
		wr(FLAGS_OFS, 32'h0, 4'h2);
		stamp_pin <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(FLAGS_OFS, 32'h0000_ff00, 32'h0, "flags cleared");
		$display("event test done");
		for (int sl = 0; sl < 4; sl++)
			for (int ev = 1; ev < 4; ev++)
			begin
				p = 1'((sl + ev) % 2);
				wr(CTRL_OFS, (32'(sl) << 21) | (32'(p) << 20) | 32'h0000_0f00, 4'hf);
				wr(FLAGS_OFS, 32'h0, 4'h2);
				pulse(11'(1 << (6 - ev)));
				@(negedge aclk);
				chk("event_out", 32'(event_out), 32'((sl == ev) ^ p));
				@(posedge aclk);
			end
		$display("routing test done");
		for (int k = 0; k < 8; k++)
		begin
			cal_clk_256hz <= k[0];
			cal_clk_1hz <= !k[0];
			wr(CTRL_OFS, {8'h0, k[2], 3'h0, k[1], 19'h0}, 4'hf);
			@(negedge aclk);
			chk("cal_out", 32'(cal_out), 32'(k[2] && (k[1] ? !k[0] : k[0])));
			@(posedge aclk);
		end
		$display("calibration test done");
		for (int c = 0; c < 8; c++)
		begin
			wr(CTRL_OFS, 32'(c), 4'hf);
			w0 = n_wtick;
			{kclk_tick, second_tick} <= {1'b1, c >= 4};
			repeat (32) @(posedge aclk);
			{kclk_tick, second_tick} <= 2'h0;
			@(posedge aclk);
			chk("wake ticks", 32'(n_wtick - w0), 32'(c >= 4 ? 32 : 32 >> (4 - c)));
			chk("wake_count_ext", 32'(wake_count_ext), 32'(c >= 6));
		end
		$display("wake clock test done");
		year_bcd <= 8'h25;
		init_ready <= 1'b1;
		pulse(11'h440);
		rd(FLAGS_OFS, 32'h0001_0030, 32'h0001_0030, "recal sync");
		pulse(11'h100);
		rd(FLAGS_OFS, 32'h0001_0038, 32'h0001_0018, "shift");
		wr(FLAGS_OFS, 32'h0000_0080, 4'hf);
		rd(FLAGS_OFS, 32'h0001_00f8, 32'h0001_00d8, "init");
		chk("init_mode", 32'(init_mode), 32'h1);
		pulse(11'h280);
		year_bcd <= 8'h00;
		wr(FLAGS_OFS, 32'h0, 4'hf);
		rd(FLAGS_OFS, 32'h0001_00ff, 32'h0000_0007, "status idle");
		$display("status test done");
		rd(8'h10, 32'hffff_ffff, 32'h0, "unmapped data");
		chk("unmapped rresp", 32'(resp_seen), 32'h2);
		wr(8'h10, 32'hffff_ffff, 4'hf);
		chk("unmapped bresp", 32'(resp_seen), 32'h2);
		$display("unmapped test done");
		stop_test;
	end

	initial
	begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		stop_test;
	end
endmodule

bind rtccs_ctrl rtccs_ctrl_chk u_chk (.*);
